// ### include/hpp_cfg.svh
// constants of the host processor port: rule summary, offsets, field positions and timing counts
//
// Function
// RULE_01: 8-bit bus, strap picks strobe timing
// RULE_02: ten address inputs decode register space
// RULE_03: separate address and data lines only
// RULE_04: serial select high gives four-wire SPI
// RULE_05: polarity and phase strapped on D7, D6
// RULE_06: D5 strap sets address and data order
// RULE_07: read/write first, burst last, always
// RULE_08: host drives chip select low to access
// RULE_09: read/write strobe pair marks and latches
// RULE_10: direction line plus data strobe latch
// RULE_11: open-drain interrupt low on unmasked events
// RULE_12: access is control bytes then one data
// RULE_13: chip select held inside an access
// RULE_14: burst increments address, no more control
// RULE_15: no burst: next bytes are control again
// RULE_16: chip select release ends burst, restarts
// RULE_17: phase one allows back-to-back accesses
// RULE_18: device is slave, master supplies clock
// RULE_19: serial select low parallel, high SPI
// RULE_20: interrupt releases after all flags cleared; code releases once no unmasked flag is set
// RULE_21: serial read drives, write updates register
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH

`define HPP_ADDR_W        10
`define HPP_DATA_W        8
`define HPP_CTL_BITS      16
`define HPP_SPI_BITS      24
// ----------------------------------------------------------------
// device registers of the port itself
// ----------------------------------------------------------------
`define HPP_IRQ_STAT_ADDR 10'h3F0
`define HPP_IRQ_MASK_ADDR 10'h3F1
`define HPP_IRQ_MASK_RST  8'hFF
// ----------------------------------------------------------------
// strap positions on the data bus
// ----------------------------------------------------------------
`define HPP_STRAP_CPOL    7
`define HPP_STRAP_CPHA    6
`define HPP_STRAP_SWAP    5
// ----------------------------------------------------------------
// host command registers
// ----------------------------------------------------------------
`define HPP_H_ADDR_LO     3'h0
`define HPP_H_ADDR_HI     3'h1
`define HPP_H_WDATA       3'h2
`define HPP_H_CTRL        3'h3
`define HPP_H_STATUS      3'h4
`define HPP_H_RDATA       3'h5
`define HPP_H_MODE        3'h6
`define HPP_CTRL_GO       0
`define HPP_CTRL_READ     1
`define HPP_MODE_SERIAL   0
`define HPP_MODE_STYLE    1
`define HPP_MODE_CPOL     2
`define HPP_MODE_CPHA     3
`define HPP_MODE_SWAP     4
`define HPP_MODE_RST      5'h00
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HPP_CLK_NS        100
`define HPP_SCLK_NS       800
`define HPP_SCLK_HALF     ((`HPP_SCLK_NS / `HPP_CLK_NS) / 2)
`define HPP_SETUP_CYC     3
`define HPP_STRB_CYC      6
`define HPP_HOLD_CYC      3
`define HPP_STRAP_CYC     3

`endif

// ### include/hpp_pkg.sv
// state types of the device end and the host end of the host processor port
package hpp_pkg;
	typedef enum logic [1:0] {HPP_CTL1, HPP_CTL2, HPP_DATA} hpp_spi_state_t;
	typedef enum logic [2:0] {HPP_IDLE, HPP_SETUP, HPP_STRB, HPP_HOLD, HPP_SPI} hpp_host_state_t;
endpackage

// ### include/hpp_if.sv
// pins between the processor and the port, resolved from the output enables
`timescale 1ns/1ps
`include "hpp_cfg.svh"
interface hpp_if;
	logic                   serial_select;
	logic                   bus_style_select;
	logic [`HPP_ADDR_W-1:0] addr;
	logic [`HPP_DATA_W-1:0] data_h;
	logic                   data_h_oe;
	logic [`HPP_DATA_W-1:0] data_d;
	logic                   data_d_oe;
	logic [`HPP_DATA_W-1:0] data;
	logic                   chip_select_n;
	logic                   read_strobe_n;
	logic                   write_strobe_n;
	logic                   spi_clk;
	logic                   spi_mosi;
	logic                   spi_miso;
	logic                   interrupt_out_n_oe;
	logic                   interrupt_out_n;

	// pull-ups on the shared data bus and the open-drain interrupt
	assign data = data_d_oe ? data_d : (data_h_oe ? data_h : {`HPP_DATA_W{1'b1}});
	assign interrupt_out_n = ~interrupt_out_n_oe;

	modport dev (
		input  serial_select, bus_style_select, addr, data, chip_select_n,
		input  read_strobe_n, write_strobe_n, spi_clk, spi_mosi,
		output data_d, data_d_oe, spi_miso, interrupt_out_n_oe
	);
	modport host (
		input  data, spi_miso, interrupt_out_n,
		output serial_select, bus_style_select, addr, data_h, data_h_oe, chip_select_n,
		output read_strobe_n, write_strobe_n, spi_clk, spi_mosi
	);
endinterface

// ### design/hpp_sync.sv
// two-flip-flop synchroniser for a bundle of pins
`timescale 1ns/1ps
module hpp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clock_i,
	input  wire logic         reset_i,
	// pins in, synchronised out
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] stage;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			stage  <= '0;
			sync_o <= '0;
		end else begin
			stage  <= pin_i;
			sync_o <= stage;
		end
	end
endmodule

// ### design/hpp_device.sv
// device end: parallel and serial access to the register space
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "hpp_cfg.svh"
module hpp_device #(
	parameter int ADDR_W = `HPP_ADDR_W,
	parameter int DATA_W = `HPP_DATA_W
) (
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              reset_i,
	// processor pins
	hpp_if.dev                     bus,
	// block side
	input  wire logic [DATA_W-1:0] irq_event_i,
	output logic                   wr_pulse_o,
	output logic      [ADDR_W-1:0] wr_addr_o,
	output logic      [DATA_W-1:0] wr_data_o,
	output logic                   serial_mode_o
);
	localparam int SW = 7 + ADDR_W + DATA_W;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SW-1:0]     sync_in;
	logic [SW-1:0]     sync_out;
	logic              sel_s;
	logic              bts_s;
	logic              cs_n_s;
	logic              rd_n_s;
	logic              wr_n_s;
	logic              sclk_s;
	logic              mosi_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;

	assign sync_in = {bus.serial_select, bus.bus_style_select, bus.chip_select_n, bus.read_strobe_n,
		bus.write_strobe_n, bus.spi_clk, bus.spi_mosi, bus.addr, bus.data};
	assign {sel_s, bts_s, cs_n_s, rd_n_s, wr_n_s, sclk_s, mosi_s, addr_s, data_s} = sync_out;

	hpp_sync #(.W(SW)) u_sync (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   (sync_in),
		.sync_o  (sync_out)
	);

	function automatic logic [ADDR_W-1:0] rev_a(input logic [ADDR_W-1:0] v);
		for (int i = 0; i < ADDR_W; i++) begin
			rev_a[i] = v[ADDR_W-1-i];
		end
	endfunction

	function automatic logic [DATA_W-1:0] rev_d(input logic [DATA_W-1:0] v);
		for (int i = 0; i < DATA_W; i++) begin
			rev_d[i] = v[DATA_W-1-i];
		end
	endfunction

	// ----------------------------------------------------------------
	// straps caught after reset release
	// ----------------------------------------------------------------
	logic [1:0] strap_cnt;
	logic       serial;
	logic       cpol;
	logic       cpha;
	logic       swap;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			strap_cnt <= 2'h0;
			serial    <= 1'b0;
			cpol      <= 1'b0;
			cpha      <= 1'b0;
			swap      <= 1'b0;
		end else if (strap_cnt != 2'(`HPP_STRAP_CYC)) begin
			strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == 2'(`HPP_STRAP_CYC - 1)) begin
				serial <= sel_s; // RULE_19 RULE_04
				cpol   <= data_s[`HPP_STRAP_CPOL]; // RULE_05
				cpha   <= data_s[`HPP_STRAP_CPHA]; // RULE_05
				swap   <= data_s[`HPP_STRAP_SWAP]; // RULE_06
			end
		end
	end

	assign serial_mode_o = serial;

	// ----------------------------------------------------------------
	// register space and interrupt flags
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] regs [2**ADDR_W];
	logic [DATA_W-1:0] irq_stat;
	logic [DATA_W-1:0] irq_mask;
	logic              wr_en;
	logic [ADDR_W-1:0] wa;
	logic [DATA_W-1:0] wd;

	function automatic logic [DATA_W-1:0] reg_read(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(`HPP_IRQ_STAT_ADDR)) begin
			reg_read = irq_stat;
		end else if (a == ADDR_W'(`HPP_IRQ_MASK_ADDR)) begin
			reg_read = irq_mask;
		end else begin
			reg_read = regs[a];
		end
	endfunction

	always_ff @(posedge clock_i) begin
		if (wr_en && wa != ADDR_W'(`HPP_IRQ_STAT_ADDR) && wa != ADDR_W'(`HPP_IRQ_MASK_ADDR)) begin
			regs[wa] <= wd;
		end
	end

	// write one clears a flag; a new event in the same cycle wins
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			irq_stat <= '0;
			irq_mask <= DATA_W'(`HPP_IRQ_MASK_RST);
		end else begin
			if (wr_en && wa == ADDR_W'(`HPP_IRQ_STAT_ADDR)) begin
				irq_stat <= (irq_stat & ~wd) | irq_event_i; // RULE_20
			end else begin
				irq_stat <= irq_stat | irq_event_i;
			end
			if (wr_en && wa == ADDR_W'(`HPP_IRQ_MASK_ADDR)) begin
				irq_mask <= wd;
			end
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			bus.interrupt_out_n_oe <= 1'b0;
		end else begin
			bus.interrupt_out_n_oe <= |(irq_stat & ~irq_mask); // RULE_11 RULE_20
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wr_pulse_o <= 1'b0;
			wr_addr_o  <= '0;
			wr_data_o  <= '0;
		end else begin
			wr_pulse_o <= wr_en;
			if (wr_en) begin
				wr_addr_o <= wa;
				wr_data_o <= wd;
			end
		end
	end

	// ----------------------------------------------------------------
	// parallel port
	// ----------------------------------------------------------------
	logic              par_cs;
	logic              data_strobe_n;
	logic              read_write_n;
	logic              par_rd;
	logic              par_wr;
	logic              par_wr_prev;
	logic              par_fire;
	logic [ADDR_W-1:0] p_addr;
	logic [DATA_W-1:0] p_data;

	// in direction-plus-strobe timing the two strobe pins change role
	assign data_strobe_n = rd_n_s;
	assign read_write_n  = wr_n_s;
	// held off until straps land: the cleared synchroniser would read as an access
	assign par_cs        = (strap_cnt == 2'(`HPP_STRAP_CYC)) & ~serial & ~cs_n_s; // RULE_08 RULE_19
	assign par_rd        = par_cs & (bts_s ? (~data_strobe_n & read_write_n) : ~rd_n_s); // RULE_01 RULE_09 RULE_10
	assign par_wr        = par_cs & (bts_s ? (~data_strobe_n & ~read_write_n) : ~wr_n_s); // RULE_09 RULE_10
	assign par_fire      = par_wr_prev & ~par_wr;

	// address and data sit on their own lines, captured while the strobe is low
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			par_wr_prev <= 1'b0;
			p_addr      <= '0;
			p_data      <= '0;
		end else begin
			par_wr_prev <= par_wr;
			if (par_wr) begin
				p_addr <= addr_s; // RULE_02 RULE_03
				p_data <= data_s;
			end
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			bus.data_d    <= '0;
			bus.data_d_oe <= 1'b0;
		end else begin
			bus.data_d    <= reg_read(addr_s); // RULE_02
			bus.data_d_oe <= par_rd; // RULE_09 RULE_10
		end
	end

	// ----------------------------------------------------------------
	// serial port
	// ----------------------------------------------------------------
	hpp_pkg::hpp_spi_state_t  sstate;
	logic                     sclk_prev;
	logic                     sample;
	logic                     byte_done;
	logic [2:0]               bit_cnt;
	logic [DATA_W-1:0]        rx_sh;
	logic [DATA_W-1:0]        rx_full;
	logic [DATA_W-1:0]        ctl_hi;
	logic [`HPP_CTL_BITS-1:0] ctl;
	logic [ADDR_W-1:0]        ctl_addr;
	logic [ADDR_W-1:0]        s_addr;
	logic                     s_rw;
	logic                     s_burst;
	logic [DATA_W-1:0]        tx;
	logic                     spi_fire;

	// master supplies the clock; sample edge follows the strapped mode
	assign sample    = serial & ~cs_n_s & (sclk_s != sclk_prev) & (sclk_s == ~(cpol ^ cpha)); // RULE_18 RULE_05
	assign byte_done = sample & (bit_cnt == 3'h7);
	assign rx_full   = {rx_sh[DATA_W-2:0], mosi_s};
	assign ctl       = {ctl_hi, rx_full};
	assign ctl_addr  = swap ? rev_a(ctl[`HPP_CTL_BITS-2 -: ADDR_W]) : ctl[`HPP_CTL_BITS-2 -: ADDR_W]; // RULE_06 RULE_07
	assign spi_fire  = byte_done & (sstate == hpp_pkg::HPP_DATA) & ~s_rw; // RULE_21

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= sclk_s;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sstate  <= hpp_pkg::HPP_CTL1;
			bit_cnt <= 3'h0;
			rx_sh   <= '0;
			ctl_hi  <= '0;
			s_addr  <= '0;
			s_rw    <= 1'b0;
			s_burst <= 1'b0;
			tx      <= '0;
		end else if (cs_n_s) begin
			sstate  <= hpp_pkg::HPP_CTL1; // RULE_16
			bit_cnt <= 3'h0;
		end else if (sample) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_sh   <= rx_full;
			if (byte_done) begin
				unique case (sstate)
					hpp_pkg::HPP_CTL1: begin
						ctl_hi <= rx_full;
						sstate <= hpp_pkg::HPP_CTL2; // RULE_12
					end
					hpp_pkg::HPP_CTL2: begin
						s_rw    <= ctl[`HPP_CTL_BITS-1]; // RULE_07
						s_burst <= ctl[0]; // RULE_07
						s_addr  <= ctl_addr;
						tx      <= reg_read(ctl_addr); // RULE_21
						sstate  <= hpp_pkg::HPP_DATA;
					end
					hpp_pkg::HPP_DATA: begin
						if (s_burst) begin
							s_addr <= s_addr + ADDR_W'(1); // RULE_14
							tx     <= reg_read(s_addr + ADDR_W'(1));
						end else begin
							sstate <= hpp_pkg::HPP_CTL1; // RULE_15 RULE_17
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			bus.spi_miso <= 1'b0;
		end else begin
			bus.spi_miso <= swap ? tx[bit_cnt] : tx[3'h7 - bit_cnt]; // RULE_06 RULE_21
		end
	end

	// ----------------------------------------------------------------
	// shared write port
	// ----------------------------------------------------------------
	always_comb begin
		wr_en = 1'b0;
		wa    = p_addr;
		wd    = p_data;
		if (par_fire) begin
			wr_en = 1'b1;
		end else if (spi_fire) begin
			wr_en = 1'b1;
			wa    = s_addr;
			wd    = swap ? rev_d(rx_full) : rx_full; // RULE_21
		end
	end
endmodule

// ### design/hpp_host.sv
// host end: drives the processor pins from a small command register file
`timescale 1ns/1ps
`include "hpp_cfg.svh"
module hpp_host #(
	parameter int ADDR_W = `HPP_ADDR_W,
	parameter int DATA_W = `HPP_DATA_W,
	parameter int HALF   = `HPP_SCLK_HALF
) (
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              reset_i,
	// processor pins
	hpp_if.host                    bus,
	// command port
	input  wire logic [2:0]        addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o
);
	localparam int NB = `HPP_SPI_BITS;

	logic [DATA_W+1:0] sync_out;
	logic [DATA_W-1:0] data_s;
	logic              miso_s;
	logic              irq_n_s;

	hpp_sync #(.W(DATA_W + 2)) u_sync (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   ({bus.data, bus.spi_miso, bus.interrupt_out_n}),
		.sync_o  (sync_out)
	);
	assign {data_s, miso_s, irq_n_s} = sync_out;

	function automatic logic [ADDR_W-1:0] rev_a(input logic [ADDR_W-1:0] v);
		for (int i = 0; i < ADDR_W; i++) begin
			rev_a[i] = v[ADDR_W-1-i];
		end
	endfunction

	function automatic logic [DATA_W-1:0] rev_d(input logic [DATA_W-1:0] v);
		for (int i = 0; i < DATA_W; i++) begin
			rev_d[i] = v[DATA_W-1-i];
		end
	endfunction

	// ----------------------------------------------------------------
	// command registers
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] t_addr;
	logic [DATA_W-1:0] t_wdata;
	logic [4:0]        mode;
	logic              t_read;
	logic              busy;
	logic              done;
	logic              finish;
	logic [DATA_W-1:0] t_rdata;
	logic              go;

	assign go = wr_i & (addr_i == `HPP_H_CTRL) & wdata_i[`HPP_CTRL_GO] & ~busy;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			t_addr  <= '0;
			t_wdata <= '0;
			mode    <= `HPP_MODE_RST;
			t_read  <= 1'b0;
		end else if (wr_i) begin
			unique case (addr_i)
				`HPP_H_ADDR_LO: t_addr[7:0] <= wdata_i;
				`HPP_H_ADDR_HI: t_addr[ADDR_W-1:8] <= wdata_i[ADDR_W-9:0];
				`HPP_H_WDATA:   t_wdata <= wdata_i;
				`HPP_H_MODE:    mode <= wdata_i[4:0];
				`HPP_H_CTRL:    t_read <= busy ? t_read : wdata_i[`HPP_CTRL_READ];
				default:        t_read <= t_read;
			endcase
		end
	end

	// done is set by the sequencer and cleared by a new start; set wins
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			done <= 1'b0;
		end else if (finish) begin
			done <= 1'b1;
		end else if (go) begin
			done <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			unique case (addr_i)
				`HPP_H_ADDR_LO: rdata_o <= t_addr[7:0];
				`HPP_H_ADDR_HI: rdata_o <= DATA_W'(t_addr[ADDR_W-1:8]);
				`HPP_H_WDATA:   rdata_o <= t_wdata;
				`HPP_H_STATUS:  rdata_o <= {5'h00, ~irq_n_s, done, busy};
				`HPP_H_RDATA:   rdata_o <= t_rdata;
				`HPP_H_MODE:    rdata_o <= {3'h0, mode};
				default:        rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

	// ----------------------------------------------------------------
	// pin sequencer
	// ----------------------------------------------------------------
	hpp_pkg::hpp_host_state_t hstate;
	logic [7:0]               cnt;
	logic [5:0]               h;
	logic [5:0]               h_new;
	logic [5:0]               bit_idx;
	logic [NB-1:0]            stream;
	logic [NB-1:0]            rx;
	logic [ADDR_W-1:0]        a_field;

	assign a_field = mode[`HPP_MODE_SWAP] ? rev_a(t_addr) : t_addr;
	// burst flag left clear: one access per start
	assign stream  = {t_read, a_field, 4'h0, 1'b0, mode[`HPP_MODE_SWAP] ? rev_d(t_wdata) : t_wdata}; // RULE_07
	assign h_new   = h + 6'h1;
	assign bit_idx = mode[`HPP_MODE_CPHA] ? ((h_new - 6'h1) >> 1) : (h_new >> 1);
	assign busy    = hstate != hpp_pkg::HPP_IDLE;
	assign finish  = (hstate == hpp_pkg::HPP_HOLD && cnt == 8'(`HPP_HOLD_CYC - 1))
		|| (hstate == hpp_pkg::HPP_SPI && cnt == 8'(HALF - 1) && h_new == 6'(2 * NB + 1));

	// straps: select pins and, in serial mode, the data bus
	assign bus.serial_select    = mode[`HPP_MODE_SERIAL];
	assign bus.bus_style_select = mode[`HPP_MODE_STYLE];

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			hstate             <= hpp_pkg::HPP_IDLE;
			cnt                <= 8'h00;
			h                  <= 6'h00;
			rx                 <= '0;
			t_rdata            <= '0;
			bus.chip_select_n  <= 1'b1;
			bus.read_strobe_n  <= 1'b1;
			bus.write_strobe_n <= 1'b1;
			bus.addr           <= '0;
			bus.data_h         <= '0;
			bus.data_h_oe      <= 1'b0;
			bus.spi_clk        <= 1'b0;
			bus.spi_mosi       <= 1'b0;
		end else begin
			cnt <= cnt + 8'h01;
			if (mode[`HPP_MODE_SERIAL]) begin
				bus.data_h    <= {mode[`HPP_MODE_CPOL], mode[`HPP_MODE_CPHA], mode[`HPP_MODE_SWAP], 5'h00};
				bus.data_h_oe <= 1'b1;
			end
			unique case (hstate)
				hpp_pkg::HPP_IDLE: begin
					bus.chip_select_n <= 1'b1;
					bus.spi_clk       <= mode[`HPP_MODE_CPOL];
					if (!mode[`HPP_MODE_SERIAL]) begin
						bus.data_h_oe <= 1'b0;
					end
					if (go) begin
						cnt               <= 8'h00;
						h                 <= 6'h00;
						bus.chip_select_n <= 1'b0; // RULE_08
						if (mode[`HPP_MODE_SERIAL]) begin
							bus.spi_mosi <= stream[NB-1];
							hstate       <= hpp_pkg::HPP_SPI;
						end else begin
							bus.addr      <= t_addr; // RULE_02 RULE_03
							bus.data_h    <= t_wdata;
							bus.data_h_oe <= ~wdata_i[`HPP_CTRL_READ];
							// direction line held through the access
							bus.write_strobe_n <= mode[`HPP_MODE_STYLE] ? wdata_i[`HPP_CTRL_READ] : 1'b1;
							hstate        <= hpp_pkg::HPP_SETUP;
						end
					end
				end
				hpp_pkg::HPP_SETUP: begin
					if (cnt == 8'(`HPP_SETUP_CYC - 1)) begin
						cnt    <= 8'h00;
						hstate <= hpp_pkg::HPP_STRB;
						if (mode[`HPP_MODE_STYLE] || t_read) begin
							bus.read_strobe_n <= 1'b0; // RULE_09 RULE_10
						end else begin
							bus.write_strobe_n <= 1'b0; // RULE_09
						end
					end
				end
				hpp_pkg::HPP_STRB: begin
					if (cnt == 8'(`HPP_STRB_CYC - 1)) begin
						cnt               <= 8'h00;
						hstate            <= hpp_pkg::HPP_HOLD;
						t_rdata           <= t_read ? data_s : t_rdata;
						bus.read_strobe_n <= 1'b1;
						if (!mode[`HPP_MODE_STYLE]) begin
							bus.write_strobe_n <= 1'b1;
						end
					end
				end
				hpp_pkg::HPP_HOLD: begin
					if (finish) begin
						hstate             <= hpp_pkg::HPP_IDLE;
						bus.chip_select_n  <= 1'b1;
						bus.write_strobe_n <= 1'b1;
					end
				end
				hpp_pkg::HPP_SPI: begin
					if (cnt == 8'(HALF - 1)) begin
						cnt         <= 8'h00;
						h           <= h_new;
						bus.spi_clk <= mode[`HPP_MODE_CPOL] ^ h_new[0]; // RULE_18
						if (bit_idx < 6'(NB)) begin
							bus.spi_mosi <= stream[5'(NB - 1) - 5'(bit_idx)];
						end
						// closing step is no clock edge: no sample there
						if (mode[`HPP_MODE_CPHA] ? (~h_new[0] && h_new >= 6'h02) : (h_new[0] && h_new < 6'(2 * NB))) begin
							rx <= {rx[NB-2:0], miso_s};
						end
						if (finish) begin
							// chip select held across all three bytes
							hstate            <= hpp_pkg::HPP_IDLE; // RULE_13
							bus.chip_select_n <= 1'b1;
							bus.spi_clk       <= mode[`HPP_MODE_CPOL];
							t_rdata           <= mode[`HPP_MODE_SWAP] ? rev_d(rx[DATA_W-1:0]) : rx[DATA_W-1:0];
						end
					end
				end
			endcase
		end
	end
endmodule

// ### verification/hpp_properties.sv
// concurrent checks on the pins between host and device
`timescale 1ns/1ps
module hpp_properties (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       reset_i,
	// pins between the two ends
	input wire logic       serial_select,
	input wire logic       bus_style_select,
	input wire logic [7:0] data,
	input wire logic       chip_select_n,
	input wire logic       read_strobe_n,
	input wire logic       write_strobe_n,
	input wire logic       data_d_oe,
	input wire logic       spi_clk
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence access_open; $fell(chip_select_n); endsequence
	sequence access_held; !chip_select_n [*8]; endsequence
	sequence strobe_open; $fell(read_strobe_n) && !serial_select; endsequence
	sequence strobe_held; !read_strobe_n [*3]; endsequence
	a_cs_held: assert property (access_open |-> access_held)
		else $error("chip select released inside an access");
	a_strobe_low: assert property (strobe_open |=> strobe_held)
		else $error("strobe shorter than four clocks");
	a_strobe_in_cs: assert property (!read_strobe_n && !serial_select |-> !chip_select_n)
		else $error("strobe active without chip select");
	a_drive_on_read: assert property ($rose(data_d_oe) |-> !chip_select_n && !read_strobe_n && write_strobe_n)
		else $error("data driven outside a read");
	a_drive_ends: assert property ($rose(read_strobe_n) && !serial_select |-> ##[1:5] !data_d_oe)
		else $error("data still driven after read");
	a_serial_quiet: assert property (serial_select |-> !data_d_oe)
		else $error("parallel data driven in serial mode");
	a_sclk_half: assert property ($changed(spi_clk) |=> $stable(spi_clk) [*3])
		else $error("serial clock half period too short");
	a_sclk_idle: assert property (chip_select_n && $past(chip_select_n) && serial_select && $past(serial_select)
		&& $stable(data)
		|-> spi_clk == data[7])
		else $error("serial clock idle level wrong");
endmodule

// ### verification/testbench.sv
// self-checking bench joining the host and device ends
`timescale 1ns/1ps
`include "hpp_cfg.svh"
module testbench;
	logic       clock_i     = 1'b0;
	logic       reset_i     = 1'b1;
	logic       dev_reset   = 1'b1;
	logic [2:0] addr_i      = 3'h0;
	logic [7:0] wdata_i     = 8'h00;
	logic       wr_i        = 1'b0;
	logic       rd_i        = 1'b0;
	logic [7:0] irq_event_i = 8'h00;
	logic [7:0] rdata_o;
	logic       wr_pulse_o;
	logic [9:0] wr_addr_o;
	logic [7:0] wr_data_o;
	logic       serial_mode_o;
	logic [7:0] rv;
	logic [9:0] n_writes    = 10'h000;
	int         failures    = 0;
	int         checks_done = 0;
	hpp_if bus();
	hpp_host u_hpp_host (.clock_i(clock_i), .reset_i(reset_i), .bus(bus), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	hpp_device u_hpp_device (.clock_i(clock_i), .reset_i(dev_reset), .bus(bus), .irq_event_i(irq_event_i),
		.wr_pulse_o(wr_pulse_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .serial_mode_o(serial_mode_o));
	hpp_properties u_hpp_properties (.clock_i(clock_i), .reset_i(dev_reset), .serial_select(bus.serial_select),
		.bus_style_select(bus.bus_style_select), .data(bus.data), .chip_select_n(bus.chip_select_n),
		.read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n), .data_d_oe(bus.data_d_oe),
		.spi_clk(bus.spi_clk));
	always #50 clock_i = ~clock_i;
	always @(posedge clock_i) if (wr_pulse_o === 1'b1) n_writes <= n_writes + 10'h001;
	task automatic report_and_stop;
		if (failures == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic hw(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic hr(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// one device access through the host, waiting for busy to drop
	task automatic dev(input logic rd, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
		hw(`HPP_H_ADDR_LO, a[7:0]);
		hw(`HPP_H_ADDR_HI, {6'h00, a[9:8]});
		hw(`HPP_H_WDATA, d);
		hw(`HPP_H_CTRL, {6'h00, rd, 1'b1});
		q = 8'h01;
		for (int n = 0; n < 500 && q[0] !== 1'b0; n++) hr(`HPP_H_STATUS, q);
		if (q[0] !== 1'b0) begin
			failures++;
			report_and_stop();
		end
		hr(`HPP_H_RDATA, q);
	endtask
	// straps are captured only at device reset release
	task automatic set_mode(input logic [4:0] m);
		hw(`HPP_H_MODE, {3'h0, m});
		@(posedge clock_i);
		dev_reset <= 1'b1;
		@(posedge clock_i);
		dev_reset <= 1'b0;
		repeat (8) @(posedge clock_i);
	endtask
	task automatic irq_pulse;
		@(posedge clock_i);
		irq_event_i <= 8'h01;
		@(posedge clock_i);
		irq_event_i <= 8'h00;
		repeat (6) @(posedge clock_i);
	endtask
	initial begin
		repeat (5) @(posedge clock_i);
		reset_i <= 1'b0;
		dev_reset <= 1'b0;
		repeat (5) @(posedge clock_i);
		for (int s = 0; s < 2; s++) begin
			set_mode({3'h0, s[0], 1'b0});
			dev(1'b0, {9'h155, s[0]}, {7'h2D, s[0]}, rv);
			check("write address", wr_addr_o, {9'h155, s[0]});
			check("write data", {2'h0, wr_data_o}, {3'h0, 6'h2D, s[0]});
			dev(1'b1, {9'h155, s[0]}, 8'h00, rv);
			check("parallel read", {2'h0, rv}, {3'h0, 6'h2D, s[0]});
			check("serial mode", {9'h000, serial_mode_o}, 10'h000);
		end
		for (int m = 0; m < 8; m++) begin
			set_mode({m[2:0], 1'b0, 1'b1});
			check("serial mode", {9'h000, serial_mode_o}, 10'h001);
			dev(1'b0, {7'h61, m[2:0]}, {m[2:0], 5'h16}, rv);
			check("spi write address", wr_addr_o, {7'h61, m[2:0]});
			check("spi write data", {2'h0, wr_data_o}, {2'h0, m[2:0], 5'h16});
			dev(1'b1, {7'h61, m[2:0]}, 8'h00, rv);
			check("spi read", {2'h0, rv}, {2'h0, m[2:0], 5'h16});
		end
		dev(1'b1, `HPP_IRQ_MASK_ADDR, 8'h00, rv);
		check("irq mask reset", {2'h0, rv}, {2'h0, `HPP_IRQ_MASK_RST});
		irq_pulse();
		check("masked irq line", {9'h000, bus.interrupt_out_n}, 10'h001);
		dev(1'b0, `HPP_IRQ_MASK_ADDR, 8'hFE, rv);
		irq_pulse();
		check("irq line", {9'h000, bus.interrupt_out_n}, 10'h000);
		dev(1'b1, `HPP_IRQ_STAT_ADDR, 8'h00, rv);
		check("irq status", {2'h0, rv}, 10'h001);
		dev(1'b0, `HPP_IRQ_STAT_ADDR, 8'h01, rv);
		repeat (6) @(posedge clock_i);
		check("irq released", {9'h000, bus.interrupt_out_n}, 10'h001);
		check("write pulses", n_writes, 10'h00C);
		report_and_stop();
	end
endmodule
